// file: verilog/supply_backup_gating.sv
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Low-supply reset blocks SRAM access and releases SRAM data and control lines.
// - Low-supply reset holds processor reset output high until it drops.
// - Bit 4 of port 0x04 turns radio-quiet mode on or off.
// - Low-supply reset or backup-isolate bit turns rail-link switch off.
// - Otherwise rail-link switch stays on so main rail charges backup rail.
// - Quiet mode plus active receive shuts the up-converter during receive.
// - While shut for backup, vibrator and backlight enables are forced off.
// - Dummy load enabled keeps up-converter running, overriding quiet shutdown.
// - Receive ending restores gated outputs; stored software settings stay untouched.
// - Up-converter shutdown combines quiet bit with current receive state.
// - Processor reset is OR of low-supply, watchdog and all-keys resets.
// - Backup-isolate is bit 2 of port 0x02, software writable.
module supply_backup_gating
  import supply_backup_pkg::*;
#(
  parameter int SRAM_DW = 8
)(
  // Clock and reset
  input  wire  logic               CLK_SYS,
  input  wire  logic               RST,
  // Avalon-MM slave
  input  wire  logic [7:0]         AVS_ADDRESS,
  input  wire  logic               AVS_READ,
  input  wire  logic               AVS_WRITE,
  input  wire  logic [31:0]        AVS_WRITEDATA,
  output logic [31:0]              AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  // Asynchronous reset sources and radio state
  input  wire  logic               LOW_SUPPLY_RESET,
  input  wire  logic               WATCHDOG_RESET_SRC,
  input  wire  logic               ALL_KEYS_RESET_SRC,
  input  wire  logic               RADIO_RECEIVE_ACTIVE,
  // Processor side of the SRAM bus
  input  wire  logic               CPU_SRAM_CE_N,
  input  wire  logic               CPU_SRAM_WE_N,
  input  wire  logic               CPU_SRAM_OE_N,
  input  wire  logic [SRAM_DW-1:0] CPU_SRAM_DQ_O,
  input  wire  logic               CPU_SRAM_DQ_OE,
  // SRAM pins
  output logic                     SRAM_CE_N,
  output logic                     SRAM_WE_N,
  output logic                     SRAM_OE_N,
  output logic                     SRAM_CTRL_OE,
  output logic [SRAM_DW-1:0]       SRAM_DQ_O,
  output logic                     SRAM_DQ_OE,
  // Power and load controls
  output logic                     CPU_RESET_OUT,
  output logic                     RAIL_LINK_SWITCH_ON,
  output logic                     UPCONV_SHUTDOWN_N,
  output logic                     VIBRATOR_EN,
  output logic                     BACKLIGHT_EN,
  output logic                     DUMMY_LOAD_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [3:0] async_in;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       low_supply_reset;
  logic       watchdog_reset_src;
  logic       all_keys_reset_src;
  logic       radio_receive_active;

  assign async_in = {RADIO_RECEIVE_ACTIVE, ALL_KEYS_RESET_SRC, WATCHDOG_RESET_SRC, LOW_SUPPLY_RESET};

  // Low supply taken as asserted while in reset, so nothing leaks early
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      sync1_reg <= 4'h1;
      sync2_reg <= 4'h1;
    end
    else
    begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign low_supply_reset     = sync2_reg[0];
  assign watchdog_reset_src   = sync2_reg[1];
  assign all_keys_reset_src   = sync2_reg[2];
  assign radio_receive_active = sync2_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave

  logic [7:0]  port02_reg;
  logic [7:0]  port04_reg;
  logic [7:0]  status_word;
  logic [5:0]  word_idx;
  logic        request;
  logic        wait_reg;
  logic [31:0] rdata_reg;

  assign word_idx = AVS_ADDRESS[7:2];
  assign request  = AVS_READ | AVS_WRITE;

  // Waitrequest drops for one cycle after a request is seen
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      wait_reg <= 1'b1;
    else if (request && wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  // Read data captured on the first cycle, so it stands when waitrequest drops
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      rdata_reg <= 32'h0000_0000;
    else if (AVS_READ && wait_reg)
    begin
      case (word_idx)
        PORT02_IDX: rdata_reg <= {24'h00_0000, port02_reg};
        PORT04_IDX: rdata_reg <= {24'h00_0000, port04_reg};
        STATUS_IDX: rdata_reg <= {24'h00_0000, status_word};
        default:    rdata_reg <= 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
  end

  // Writes land on the completing edge only; unmapped writes vanish
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      port02_reg <= PORT02_RESET;
      port04_reg <= PORT04_RESET;
    end
    else if (AVS_WRITE && !wait_reg)
    begin
      if (word_idx == PORT02_IDX)
        port02_reg <= AVS_WRITEDATA[7:0];
      if (word_idx == PORT04_IDX)
        port04_reg <= AVS_WRITEDATA[7:0];
    end
  end

  assign AVS_WAITREQUEST = wait_reg;
  assign AVS_READDATA    = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Power gating decisions

  logic radio_quiet_mode;
  logic backup_isolate_n;
  logic shut_next;
  logic switch_next;
  logic cpu_reset_next;
  sram_ctrl_t cpu_ctrl;
  sram_ctrl_t ctrl_next;

  assign radio_quiet_mode = port04_reg[QUIET_BIT];
  assign backup_isolate_n = ~port02_reg[ISOLATE_BIT];

  // Dummy load outranks quiet mode; pure level logic so receive end restores all
  assign shut_next = radio_quiet_mode & radio_receive_active & ~port04_reg[DUMMY_BIT];

  // Switch cannot be re-closed by software while supply is low
  assign switch_next = ~low_supply_reset & backup_isolate_n;

  assign cpu_reset_next = low_supply_reset | watchdog_reset_src | all_keys_reset_src;

  assign cpu_ctrl  = '{ce_n: CPU_SRAM_CE_N, we_n: CPU_SRAM_WE_N, oe_n: CPU_SRAM_OE_N};
  assign ctrl_next = low_supply_reset ? SRAM_IDLE : cpu_ctrl;

  // Load and power outputs, registered
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      CPU_RESET_OUT       <= 1'b1;
      RAIL_LINK_SWITCH_ON <= 1'b0;
      UPCONV_SHUTDOWN_N   <= 1'b1;
      VIBRATOR_EN         <= 1'b0;
      BACKLIGHT_EN        <= 1'b0;
      DUMMY_LOAD_EN       <= 1'b0;
    end
    else
    begin
      CPU_RESET_OUT       <= cpu_reset_next;
      RAIL_LINK_SWITCH_ON <= switch_next;
      UPCONV_SHUTDOWN_N   <= ~shut_next;
      VIBRATOR_EN         <= port04_reg[VIBRATOR_BIT] & ~shut_next;
      BACKLIGHT_EN        <= port04_reg[BACKLIGHT_BIT] & ~shut_next;
      DUMMY_LOAD_EN       <= port04_reg[DUMMY_BIT];
    end
  end

  // SRAM lines; released entirely while supply is low to protect contents
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      SRAM_CE_N    <= SRAM_IDLE.ce_n;
      SRAM_WE_N    <= SRAM_IDLE.we_n;
      SRAM_OE_N    <= SRAM_IDLE.oe_n;
      SRAM_CTRL_OE <= 1'b0;
      SRAM_DQ_O    <= '0;
      SRAM_DQ_OE   <= 1'b0;
    end
    else
    begin
      SRAM_CE_N    <= ctrl_next.ce_n;
      SRAM_WE_N    <= ctrl_next.we_n;
      SRAM_OE_N    <= ctrl_next.oe_n;
      SRAM_CTRL_OE <= ~low_supply_reset;
      SRAM_DQ_O    <= CPU_SRAM_DQ_O;
      SRAM_DQ_OE   <= CPU_SRAM_DQ_OE & ~low_supply_reset;
    end
  end

  // Status view of live state for software
  assign status_word = {2'b00, ~SRAM_CTRL_OE, RAIL_LINK_SWITCH_ON, ~UPCONV_SHUTDOWN_N,
                        radio_receive_active, CPU_RESET_OUT, low_supply_reset};

endmodule
`default_nettype wire

// file: verilog/supply_backup_pkg.sv
`default_nettype none
package supply_backup_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] PORT02_IDX  = 6'h02;
  localparam logic [5:0] PORT04_IDX  = 6'h04;
  localparam logic [5:0] STATUS_IDX  = 6'h06;

  // Field positions in port 0x02
  localparam int ISOLATE_BIT  = 2;
  // Field positions in port 0x04
  localparam int VIBRATOR_BIT = 0;
  localparam int BACKLIGHT_BIT = 1;
  localparam int DUMMY_BIT    = 3;
  localparam int QUIET_BIT    = 4;

  // Status field positions
  localparam int ST_LOW_SUPPLY = 0;
  localparam int ST_CPU_RESET  = 1;
  localparam int ST_RX_ACTIVE  = 2;
  localparam int ST_SHUTDOWN   = 3;
  localparam int ST_SWITCH_ON  = 4;
  localparam int ST_SRAM_BLOCK = 5;

  // Reset values
  localparam logic [7:0] PORT02_RESET = 8'h00;
  localparam logic [7:0] PORT04_RESET = 8'h00;

  // SRAM control strobes, all active low
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
  } sram_ctrl_t;

  localparam sram_ctrl_t SRAM_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};

endpackage
`default_nettype wire

// file: verilog/placeholder_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: testbench/supply_backup_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module supply_backup_monitor (
  // Clock, reset and bus handshake
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // Level inputs and processor strobes
  input wire logic LOW_SUPPLY_RESET,
  input wire logic WATCHDOG_RESET_SRC,
  input wire logic ALL_KEYS_RESET_SRC,
  input wire logic RADIO_RECEIVE_ACTIVE,
  input wire logic       CPU_SRAM_CE_N,
  input wire logic       CPU_SRAM_WE_N,
  input wire logic       CPU_SRAM_OE_N,
  input wire logic [7:0] CPU_SRAM_DQ_O,
  input wire logic       CPU_SRAM_DQ_OE,
  // Outputs watched
  input wire logic       SRAM_CE_N,
  input wire logic       SRAM_WE_N,
  input wire logic       SRAM_OE_N,
  input wire logic [7:0] SRAM_DQ_O,
  input wire logic SRAM_CTRL_OE,
  input wire logic SRAM_DQ_OE,
  input wire logic CPU_RESET_OUT,
  input wire logic RAIL_LINK_SWITCH_ON,
  input wire logic UPCONV_SHUTDOWN_N,
  input wire logic VIBRATOR_EN,
  input wire logic BACKLIGHT_EN,
  input wire logic DUMMY_LOAD_EN
);
  logic [2:0] settle_reg;
  logic       ready;
  // Synchronisers start in low-supply state, so pin relations wait a few edges
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST) settle_reg <= 3'h0;
    else if (!ready) settle_reg <= settle_reg + 3'h1;
  assign ready = (settle_reg == 3'h7);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////
  AST_SRAM_BLOCK: assert property (ready && $past(LOW_SUPPLY_RESET, 3) |->
    !SRAM_CTRL_OE && !SRAM_DQ_OE && SRAM_CE_N && SRAM_WE_N && SRAM_OE_N) else $error("SRAM driven during low supply");
  AST_SRAM_PASS: assert property (ready && !$past(LOW_SUPPLY_RESET, 3) |-> SRAM_CTRL_OE &&
    SRAM_CE_N == $past(CPU_SRAM_CE_N) && SRAM_WE_N == $past(CPU_SRAM_WE_N) &&
    SRAM_OE_N == $past(CPU_SRAM_OE_N) && SRAM_DQ_OE == $past(CPU_SRAM_DQ_OE)) else $error("SRAM path wrong");
  AST_SRAM_DATA: assert property (ready |-> SRAM_DQ_O == $past(CPU_SRAM_DQ_O))
    else $error("SRAM data path wrong");
  AST_CPU_RESET: assert property (ready |-> CPU_RESET_OUT == ($past(LOW_SUPPLY_RESET, 3) ||
    $past(WATCHDOG_RESET_SRC, 3) || $past(ALL_KEYS_RESET_SRC, 3))) else $error("processor reset wrong");
  AST_SWITCH_LOW: assert property (ready && $past(LOW_SUPPLY_RESET, 3) |-> !RAIL_LINK_SWITCH_ON)
    else $error("switch on in low supply");
  AST_SHUT_CAUSE: assert property (ready && !UPCONV_SHUTDOWN_N |-> $past(RADIO_RECEIVE_ACTIVE, 3))
    else $error("shutdown without receive");
  AST_RX_RESTORE: assert property (ready && !$past(RADIO_RECEIVE_ACTIVE, 3) |-> UPCONV_SHUTDOWN_N)
    else $error("converter not restored");
  AST_LOADS_OFF: assert property (!UPCONV_SHUTDOWN_N |-> !VIBRATOR_EN && !BACKLIGHT_EN)
    else $error("loads on in backup");
  AST_DUMMY_WINS: assert property (DUMMY_LOAD_EN |-> UPCONV_SHUTDOWN_N)
    else $error("converter shut with dummy load");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  AST_WAIT_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus not answered");
  // Main scenarios reached
  cover property (!UPCONV_SHUTDOWN_N);
  cover property (ready && !RAIL_LINK_SWITCH_ON && !$past(LOW_SUPPLY_RESET, 3));
  cover property (DUMMY_LOAD_EN && RADIO_RECEIVE_ACTIVE);
endmodule
bind supply_backup_gating supply_backup_monitor u_mon (.*);
`default_nettype wire

// file: testbench/cpu_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_sram_model
  import supply_backup_pkg::*;
(
  // Clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RST,
  // Processor SRAM strobes
  output sram_ctrl_t ctrl,
  output logic [7:0] dq,
  output logic       dq_oe
);
  logic [10:0] pat_reg;
  // Odd step so every strobe and data bit moves often
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST) pat_reg <= 11'h000;
    else pat_reg <= pat_reg + 11'h1f3;
  // Processor in reset leaves the bus idle
  assign ctrl  = RST ? SRAM_IDLE : sram_ctrl_t'(pat_reg[2:0]);
  assign dq    = RST ? 8'h00 : pat_reg[10:3];
  assign dq_oe = pat_reg[5] & ~RST;
endmodule
`default_nettype wire

// file: testbench/supply_backup_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supply_backup_gating_tb;
  import supply_backup_pkg::*;
  logic        CLK_SYS = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST;
  logic [7:0]  AVS_ADDRESS = 8'h00, p02, p04, st;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, exp_q[$];
  logic [3:0]  pin = 4'h0;
  logic        shut, cpu_dq_oe, VIBRATOR_EN, BACKLIGHT_EN, RAIL_LINK_SWITCH_ON, UPCONV_SHUTDOWN_N;
  logic        DUMMY_LOAD_EN;
  logic [7:0]  cpu_dq;
  sram_ctrl_t  cpu_ctrl;
  integer      errors = 0, checks_done = 0, seed = 32'hbee3;
  always #12.5 CLK_SYS = ~CLK_SYS;
  cpu_sram_model u_cpu (.CLK_SYS(CLK_SYS), .RST(RST), .ctrl(cpu_ctrl), .dq(cpu_dq), .dq_oe(cpu_dq_oe));
  supply_backup_gating u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LOW_SUPPLY_RESET(pin[3]), .WATCHDOG_RESET_SRC(pin[2]),
    .ALL_KEYS_RESET_SRC(pin[1]), .RADIO_RECEIVE_ACTIVE(pin[0]), .CPU_SRAM_CE_N(cpu_ctrl.ce_n),
    .CPU_SRAM_WE_N(cpu_ctrl.we_n), .CPU_SRAM_OE_N(cpu_ctrl.oe_n), .CPU_SRAM_DQ_O(cpu_dq),
    .CPU_SRAM_DQ_OE(cpu_dq_oe), .SRAM_CE_N(), .SRAM_WE_N(), .SRAM_OE_N(), .SRAM_CTRL_OE(), .SRAM_DQ_O(),
    .SRAM_DQ_OE(), .CPU_RESET_OUT(), .RAIL_LINK_SWITCH_ON(RAIL_LINK_SWITCH_ON),
    .UPCONV_SHUTDOWN_N(UPCONV_SHUTDOWN_N), .VIBRATOR_EN(VIBRATOR_EN), .BACKLIGHT_EN(BACKLIGHT_EN),
    .DUMMY_LOAD_EN(DUMMY_LOAD_EN));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Held until waitrequest low, then one idle edge so no signal is set twice
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  // Read results compared in order as they land
  always @(posedge CLK_SYS)
    if (AVS_READ && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0)
      check("readdata", AVS_READDATA, exp_q.pop_front());
  initial
  begin
    repeat (20000) @(posedge CLK_SYS);
    errors++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    bus(1'b1, 8'h3c, 32'hff);
    rd(8'h3c, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      pin <= 4'($random(seed));
      p04 = 8'($random(seed));
      p02 = 8'($random(seed));
      @(posedge CLK_SYS);
      shut = p04[QUIET_BIT] & pin[0] & ~p04[DUMMY_BIT];
      if (shut) p02[ISOLATE_BIT] = 1'b0;
      bus(1'b1, 8'h08, {24'h0, p02});
      bus(1'b1, 8'h10, {24'h0, p04});
      repeat (4) @(posedge CLK_SYS);
      st = {2'b00, pin[3], !pin[3] && !p02[ISOLATE_BIT], shut, pin[0], |pin[3:1], pin[3]};
      rd(8'h18, {24'h0, st});
      rd(8'h10, {24'h0, p04});
      rd(8'h08, {24'h0, p02});
      check("switch", 32'(RAIL_LINK_SWITCH_ON), 32'(!pin[3] && !p02[ISOLATE_BIT]));
      check("dummy", 32'(DUMMY_LOAD_EN), 32'(p04[DUMMY_BIT]));
      if (!pin[3])
        check("loads", 32'({VIBRATOR_EN, BACKLIGHT_EN, UPCONV_SHUTDOWN_N}),
          32'({p04[VIBRATOR_BIT] & ~shut, p04[BACKLIGHT_BIT] & ~shut, ~shut}));
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
